// File: timer_pkg.sv
`default_nettype none
package timer_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte addresses, one aligned word each
  localparam logic [7:0] ADDR_STATUS_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_COUNTER_HIGH    = 8'h04;
  localparam logic [7:0] ADDR_COUNTER_LOW     = 8'h08;
  localparam logic [7:0] ADDR_MODULO_HIGH     = 8'h0C;
  localparam logic [7:0] ADDR_MODULO_LOW      = 8'h10;
  localparam logic [7:0] ADDR_CHANNEL_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_CHANNEL_VALUE_H = 8'h18;
  localparam logic [7:0] ADDR_CHANNEL_VALUE_L = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////////
  // Timer status and control fields
  localparam int OVF_FLAG_BIT   = 7;
  localparam int OVF_IE_BIT     = 6;
  localparam int CENTER_SEL_BIT = 5;
  localparam int CLK_SRC_HI     = 4;
  localparam int CLK_SRC_LO     = 3;
  localparam int PRESCALE_HI    = 2;

  // Channel status and control fields
  localparam int CHAN_FLAG_BIT  = 7;
  localparam int CHAN_IE_BIT    = 6;
  localparam int MODE_HIGH_BIT  = 5;
  localparam int MODE_LOW_BIT   = 4;
  localparam int EDGE_LEVEL_HI  = 3;
  localparam int EDGE_LEVEL_LO  = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock source select encodings
  localparam logic [1:0] CLOCK_SOURCE_SELECT_NONE  = 2'h0;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_BUS   = 2'h1;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_FIXED = 2'h2;
  localparam logic [1:0] CLOCK_SOURCE_SELECT_EXT   = 2'h3;

  // Edge/level select encoding that detaches the pin
  localparam logic [1:0] ELS_DETACHED = 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset, plus the free-run modulo code and the counter top
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] MODULO_RESET  = 16'h0000;
  localparam logic [15:0] CHAN_VAL_RESET = 16'h0000;
  localparam logic [15:0] MODULO_FREE   = 16'h0000;
  localparam logic [15:0] COUNTER_MAX   = 16'hFFFF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_EDGE_PWM,
    MODE_CENTER_PWM
  } chan_mode_t;

endpackage
`default_nettype wire

// File: timer_channel_config.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Counter bytes read coherently in either order
// - Counter or control writes restart coherency
// - Reset clears the counter
// - Background mode freezes counter and latches
// - Up mode: wrap to zero, set overflow
// - Center mode: turn down at modulo, overflow
// - Half-written modulo suppresses overflow flag
// - Modulo resets to zero, meaning free-run
// - Channel interrupt enable at bit six
// - Mode high bit selects edge PWM
// - Mode low bit: capture or compare
// - Edge/level zero detaches the pin
// - Capture edge chosen by edge/level field
// - Compare pin action chosen by field
// - Edge PWM polarity from edge/level field
// - Center select forces center PWM everywhere
// - Overflow flag clears by read then zero
// - Clock source zero stops the timer
module timer_channel_config
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AXI4-Lite write channels
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // AXI4-Lite read channels
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // Device pins
  input  wire logic        BACKGROUND_ACTIVE,
  input  wire logic        FIXED_SYSTEM_CLOCK,
  input  wire logic        CHANNEL_ZERO_PIN_I,
  output logic             CHANNEL_ZERO_PIN_O,
  output logic             CHANNEL_ZERO_PIN_OE,
  // Interrupt requests
  output logic             OVERFLOW_IRQ,
  output logic             CHANNEL_IRQ
);

  typedef struct packed {
    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic        overflow_flag;
    logic        tof_armed;
    logic        overflow_irq_enable;
    logic        cpwm;
    logic [1:0]  clock_source_select;
    logic [2:0]  ps;
    logic [6:0]  pre_cnt;
    logic [15:0] cnt;
    logic        count_down;
    logic [15:0] modulo;
    logic [1:0]  mod_pend;
    logic [15:0] cnt_buf;
    logic        cnt_latched;
    logic        latch_first_high;
    logic        chf;
    logic        chf_armed;
    logic        chie;
    logic        msh;
    logic        msl;
    logic [1:0]  els;
    logic [15:0] chv;
    logic        pin_out;
    logic        bdm_s1;
    logic        bdm_s2;
    logic        fix_s1;
    logic        fix_s2;
    logic        fix_s3;
    logic        pin_s1;
    logic        pin_s2;
    logic        pin_s3;
  } state_t;

  state_t      r;
  state_t      n;
  logic        do_wr;
  logic        wr_en;
  logic        do_rd;
  logic        wr_tsc;
  logic        wr_cnt;
  logic        wr_mod_hi;
  logic        wr_mod_lo;
  logic        wr_csc;
  logic        rd_tsc;
  logic        rd_cnt_hi;
  logic        rd_cnt_lo;
  logic        rd_csc;
  logic        src_tick;
  logic        tick;
  logic        ovf;
  logic        ovf_set;
  logic        match;
  logic        rise;
  logic        fall;
  logic        ch_event;
  logic [6:0]  mask;
  logic [15:0] top;
  logic [1:0]  pend_all;
  chan_mode_t  mode;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      ADDR_STATUS_CONTROL, ADDR_COUNTER_HIGH, ADDR_COUNTER_LOW,
      ADDR_MODULO_HIGH, ADDR_MODULO_LOW, ADDR_CHANNEL_CONTROL,
      ADDR_CHANNEL_VALUE_H, ADDR_CHANNEL_VALUE_L: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign AWREADY             = !r.aw_held;
  assign WREADY              = !r.w_held;
  assign BVALID              = r.bvalid;
  assign BRESP               = r.bresp;
  assign ARREADY             = !r.rvalid;
  assign RVALID              = r.rvalid;
  assign RDATA               = {24'h000000, r.rdata};
  assign RRESP               = r.rresp;
  assign CHANNEL_ZERO_PIN_O  = r.pin_out;
  assign CHANNEL_ZERO_PIN_OE = (r.els != ELS_DETACHED) && (mode != MODE_CAPTURE);
  assign OVERFLOW_IRQ        = r.overflow_flag && r.overflow_irq_enable && (r.mod_pend == 2'b00);
  assign CHANNEL_IRQ         = r.chf && r.chie;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n         = r;
    do_wr     = r.aw_held && r.w_held && !r.bvalid;
    wr_en     = do_wr && r.w_lane0;
    do_rd     = ARVALID && !r.rvalid;
    wr_tsc    = wr_en && (r.aw_addr == ADDR_STATUS_CONTROL);
    wr_cnt    = wr_en && ((r.aw_addr == ADDR_COUNTER_HIGH) || (r.aw_addr == ADDR_COUNTER_LOW));
    wr_mod_hi = wr_en && (r.aw_addr == ADDR_MODULO_HIGH);
    wr_mod_lo = wr_en && (r.aw_addr == ADDR_MODULO_LOW);
    wr_csc    = wr_en && (r.aw_addr == ADDR_CHANNEL_CONTROL);
    rd_tsc    = do_rd && (ARADDR == ADDR_STATUS_CONTROL);
    rd_cnt_hi = do_rd && (ARADDR == ADDR_COUNTER_HIGH);
    rd_cnt_lo = do_rd && (ARADDR == ADDR_COUNTER_LOW);
    rd_csc    = do_rd && (ARADDR == ADDR_CHANNEL_CONTROL);
    rise      = r.pin_s2 && !r.pin_s3;
    fall      = !r.pin_s2 && r.pin_s3;
    ovf       = 1'b0;
    ch_event  = 1'b0;
    pend_all  = r.mod_pend | {wr_mod_lo, wr_mod_hi};

    // Input synchronisers
    n.bdm_s1 = BACKGROUND_ACTIVE;
    n.bdm_s2 = r.bdm_s1;
    n.fix_s1 = FIXED_SYSTEM_CLOCK;
    n.fix_s2 = r.fix_s1;
    n.fix_s3 = r.fix_s2;
    n.pin_s1 = CHANNEL_ZERO_PIN_I;
    n.pin_s2 = r.pin_s1;
    n.pin_s3 = r.pin_s2;

    // Write address and data are taken in either order
    if (AWVALID && !r.aw_held) begin
      n.aw_held = 1'b1;
      n.aw_addr = AWADDR;
    end
    if (WVALID && !r.w_held) begin
      n.w_held  = 1'b1;
      n.w_data  = WDATA[7:0];
      n.w_lane0 = WSTRB[0];
    end
    if (r.bvalid && BREADY) begin
      n.bvalid = 1'b0;
    end
    if (do_wr) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = is_mapped(r.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end

    // Read answer one cycle after the address is taken
    if (r.rvalid && RREADY) begin
      n.rvalid = 1'b0;
    end
    if (do_rd) begin
      n.rvalid = 1'b1;
      n.rresp  = is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (ARADDR)
        ADDR_STATUS_CONTROL:  n.rdata = {r.overflow_flag, r.overflow_irq_enable, r.cpwm, r.clock_source_select, r.ps};
        ADDR_COUNTER_HIGH:    n.rdata = r.cnt_latched ? r.cnt_buf[15:8] : r.cnt[15:8];
        ADDR_COUNTER_LOW:     n.rdata = r.cnt_latched ? r.cnt_buf[7:0] : r.cnt[7:0];
        ADDR_MODULO_HIGH:     n.rdata = r.modulo[15:8];
        ADDR_MODULO_LOW:      n.rdata = r.modulo[7:0];
        ADDR_CHANNEL_CONTROL: n.rdata = {r.chf, r.chie, r.msh, r.msl, r.els, 2'b00};
        ADDR_CHANNEL_VALUE_H: n.rdata = r.chv[15:8];
        ADDR_CHANNEL_VALUE_L: n.rdata = r.chv[7:0];
        default:              n.rdata = 8'h00;
      endcase
    end

    // Clock source and prescaler, halted in background mode
    case (r.clock_source_select)
      CLOCK_SOURCE_SELECT_BUS:   src_tick = 1'b1;
      CLOCK_SOURCE_SELECT_FIXED: src_tick = r.fix_s2 && !r.fix_s3;
      CLOCK_SOURCE_SELECT_EXT:   src_tick = rise;
      default:    src_tick = 1'b0;
    endcase
    mask = 7'((8'h01 << r.ps) - 8'h01);
    tick = src_tick && !r.bdm_s2 && ((r.pre_cnt & mask) == mask);
    if (src_tick && !r.bdm_s2) begin
      n.pre_cnt = r.pre_cnt + 7'h01;
    end

    // Counter
    top = (r.modulo == MODULO_FREE) ? COUNTER_MAX : r.modulo;
    if (tick) begin
      if (!r.cpwm) begin
        if (r.cnt == top) begin
          n.cnt = COUNTER_RESET;
          ovf   = 1'b1;
        end else begin
          n.cnt = r.cnt + 16'h0001;
        end
      end else if (!r.count_down) begin
        if (r.cnt >= top) begin
          n.count_down = 1'b1;
          n.cnt        = r.cnt - 16'h0001;
          ovf          = 1'b1;
        end else begin
          n.cnt = r.cnt + 16'h0001;
        end
      end else if (r.cnt == COUNTER_RESET) begin
        n.count_down = 1'b0;
        n.cnt        = r.cnt + 16'h0001;
      end else begin
        n.cnt = r.cnt - 16'h0001;
      end
    end
    ovf_set = ovf && (r.mod_pend == 2'b00);

    // Counter read coherency, frozen in background mode
    if (!r.bdm_s2 && (rd_cnt_hi || rd_cnt_lo)) begin
      if (!r.cnt_latched) begin
        n.cnt_latched      = 1'b1;
        n.cnt_buf          = r.cnt;
        n.latch_first_high = rd_cnt_hi;
      end else if (rd_cnt_hi != r.latch_first_high) begin
        n.cnt_latched = 1'b0;
      end
    end

    // Channel function
    if (r.cpwm) begin
      mode = MODE_CENTER_PWM;
    end else if (r.msh) begin
      mode = MODE_EDGE_PWM;
    end else if (r.msl) begin
      mode = MODE_COMPARE;
    end else begin
      mode = MODE_CAPTURE;
    end
    match = tick && (r.cnt == r.chv);
    case (mode)
      MODE_CAPTURE: begin
        if ((r.els[0] && rise) || (r.els[1] && fall)) begin
          ch_event = 1'b1;
          n.chv    = r.cnt;
        end
      end
      MODE_COMPARE: begin
        if (match) begin
          ch_event = 1'b1;
          case (r.els)
            2'b01:   n.pin_out = !r.pin_out;
            2'b10:   n.pin_out = 1'b0;
            2'b11:   n.pin_out = 1'b1;
            default: n.pin_out = r.pin_out;
          endcase
        end
      end
      MODE_EDGE_PWM: begin
        if (match) begin
          ch_event  = 1'b1;
          n.pin_out = r.els[0];
        end
        if (ovf) begin
          n.pin_out = !r.els[0];
        end
      end
      MODE_CENTER_PWM: begin
        if (match) begin
          ch_event  = 1'b1;
          n.pin_out = r.count_down ? !r.els[0] : r.els[0];
        end
      end
      default: ch_event = 1'b0;
    endcase

    // Flag clearing: read while set arms, write of zero clears
    if (rd_tsc && r.overflow_flag) begin
      n.tof_armed = 1'b1;
    end
    if (wr_tsc && !r.w_data[OVF_FLAG_BIT] && r.tof_armed) begin
      n.overflow_flag       = 1'b0;
      n.tof_armed = 1'b0;
    end
    if (ovf_set) begin
      n.overflow_flag       = 1'b1;
      n.tof_armed = 1'b0;
    end
    if (rd_csc && r.chf) begin
      n.chf_armed = 1'b1;
    end
    if (wr_csc && !r.w_data[CHAN_FLAG_BIT] && r.chf_armed) begin
      n.chf       = 1'b0;
      n.chf_armed = 1'b0;
    end
    if (ch_event) begin
      n.chf       = 1'b1;
      n.chf_armed = 1'b0;
    end

    // Register writes
    if (wr_tsc) begin
      n.overflow_irq_enable        = r.w_data[OVF_IE_BIT];
      n.cpwm        = r.w_data[CENTER_SEL_BIT];
      n.clock_source_select        = r.w_data[CLK_SRC_HI:CLK_SRC_LO];
      n.ps          = r.w_data[PRESCALE_HI:0];
      n.cnt_latched = 1'b0;
    end
    if (wr_cnt) begin
      n.cnt         = COUNTER_RESET;
      n.count_down  = 1'b0;
      n.pre_cnt     = 7'h00;
      n.cnt_latched = 1'b0;
    end
    if (wr_mod_hi) begin
      n.modulo[15:8] = r.w_data;
    end
    if (wr_mod_lo) begin
      n.modulo[7:0] = r.w_data;
    end
    if (wr_mod_hi || wr_mod_lo) begin
      n.mod_pend = (pend_all == 2'b11) ? 2'b00 : pend_all;
    end
    if (wr_csc) begin
      n.chie = r.w_data[CHAN_IE_BIT];
      n.msh  = r.w_data[MODE_HIGH_BIT];
      n.msl  = r.w_data[MODE_LOW_BIT];
      n.els  = r.w_data[EDGE_LEVEL_HI:EDGE_LEVEL_LO];
    end
    if (wr_en && (r.aw_addr == ADDR_CHANNEL_VALUE_H)) begin
      n.chv[15:8] = r.w_data;
    end
    if (wr_en && (r.aw_addr == ADDR_CHANNEL_VALUE_L)) begin
      n.chv[7:0] = r.w_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      r        <= '0;
      r.cnt    <= COUNTER_RESET;
      r.modulo <= MODULO_RESET;
      r.chv    <= CHAN_VAL_RESET;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_first_cnt_read;
    !r.bdm_s2 && !r.cnt_latched && (rd_cnt_hi || rd_cnt_lo) && !wr_tsc && !wr_cnt;
  endsequence

  sequence s_tof_armed;
    r.overflow_flag && r.tof_armed;
  endsequence

  chk_read_latch: assert property (s_first_cnt_read |=> r.cnt_latched && r.cnt_buf == $past(r.cnt))
    else $error("counter byte read did not latch the counter");
  chk_latch_restart: assert property ((wr_tsc || wr_cnt) |=> !r.cnt_latched)
    else $error("coherency latch not restarted by write");
  chk_bdm_freeze: assert property (r.bdm_s2 && !do_wr |=> $stable(r.cnt) && $stable(r.cnt_latched))
    else $error("counter or latch moved in background mode");
  chk_up_wrap: assert property (tick && !r.cpwm && r.cnt == top && !wr_cnt && r.mod_pend == 2'b00
                                |=> r.cnt == COUNTER_RESET && r.overflow_flag)
    else $error("up count did not wrap with overflow");
  chk_center_turn: assert property (tick && r.cpwm && !r.count_down && r.cnt >= top && !wr_cnt
                                    |=> r.count_down)
    else $error("center count did not turn down");
  chk_mod_inhibit: assert property (r.mod_pend != 2'b00 && !r.overflow_flag |=> !r.overflow_flag)
    else $error("overflow flag set during modulo update");
  chk_no_clock: assert property (r.clock_source_select == CLOCK_SOURCE_SELECT_NONE && !wr_tsc && !wr_cnt |=> $stable(r.cnt))
    else $error("counter moved with no clock source");
  chk_pin_detach: assert property (r.els == ELS_DETACHED |-> !CHANNEL_ZERO_PIN_OE)
    else $error("detached pin still driven");
  chk_capture_copy: assert property (mode == MODE_CAPTURE && r.els == 2'b01 && rise && !wr_en
                                     |=> r.chf && r.chv == $past(r.cnt))
    else $error("capture did not copy counter and flag");
  chk_tof_clear: assert property (s_tof_armed ##0 (wr_tsc && !r.w_data[OVF_FLAG_BIT] && !ovf_set)
                                  |=> !r.overflow_flag)
    else $error("overflow flag clear sequence failed");
  chk_tof_unarmed: assert property (r.overflow_flag && !r.tof_armed |=> r.overflow_flag)
    else $error("overflow flag cleared without a read");
  chk_epwm_clear: assert property (mode == MODE_EDGE_PWM && r.els == 2'b10 && match && !ovf
                                   && !wr_csc |=> !CHANNEL_ZERO_PIN_O)
    else $error("edge PWM did not clear on compare");
  chk_chan_irq: assert property (r.chie && $rose(r.chf) |-> CHANNEL_IRQ)
    else $error("channel interrupt not raised");

endmodule
`default_nettype wire

// File: channel_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
module channel_pin_partner (
  // Clock
  input  wire logic clk,
  // Pin as driven by the device
  input  wire logic pin_o,
  input  wire logic pin_oe,
  // Level the outside circuit puts on the pin while the device lets go
  input  wire logic level,
  output logic      pin_i,
  // Slow reference clock, one eighth of the bus rate
  output logic      fixed_clk
);
  logic [1:0] div_r;

  initial begin
    div_r = 2'h0;
    fixed_clk = 1'b0;
  end

  // Outside circuit holds the pin steady except on a requested edge
  assign pin_i = pin_oe ? pin_o : level;

  always @(posedge clk) begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3) fixed_clk <= ~fixed_clk;
  end
endmodule
`default_nettype wire

// File: timer_channel_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module timer_channel_config_tb
  import timer_pkg::*;
;
  localparam logic [7:0] SC = ADDR_STATUS_CONTROL, NH = ADDR_COUNTER_HIGH;
  localparam logic [7:0] NL = ADDR_COUNTER_LOW, MH = ADDR_MODULO_HIGH;
  localparam logic [7:0] ML = ADDR_MODULO_LOW, CC = ADDR_CHANNEL_CONTROL;
  localparam logic [7:0] VH = ADDR_CHANNEL_VALUE_H, VL = ADDR_CHANNEL_VALUE_L;
  ////////////////////////////////////////////////////////////////////////////////
  logic        clk, rst_n, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY, bg, fsc, pin_i, pin_o, pin_oe;
  logic        ovf_irq, ch_irq, lvl, p;
  logic [7:0]  AWADDR, ARADDR, b, h, l;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rsp;
  logic [15:0] v0, v1;
  int          bad_count, comparisons, hic, e;
  logic [7:0]  regs [6] = '{SC, NH, NL, MH, ML, CC};
  logic [1:0]  ord [4] = '{2'h2, 2'h3, 2'h1, 2'h0};

  timer_channel_config u_dut (
    .CLK (clk), .RST_N (rst_n),
    .AWVALID (AWVALID), .AWREADY (AWREADY), .AWADDR (AWADDR),
    .WVALID (WVALID), .WREADY (WREADY), .WDATA (WDATA), .WSTRB (WSTRB),
    .BVALID (BVALID), .BREADY (BREADY), .BRESP (BRESP),
    .ARVALID (ARVALID), .ARREADY (ARREADY), .ARADDR (ARADDR),
    .RVALID (RVALID), .RREADY (RREADY), .RDATA (RDATA), .RRESP (RRESP),
    .BACKGROUND_ACTIVE (bg), .FIXED_SYSTEM_CLOCK (fsc),
    .CHANNEL_ZERO_PIN_I (pin_i), .CHANNEL_ZERO_PIN_O (pin_o),
    .CHANNEL_ZERO_PIN_OE (pin_oe), .OVERFLOW_IRQ (ovf_irq), .CHANNEL_IRQ (ch_irq)
  );

  channel_pin_partner u_pin (
    .clk (clk), .pin_o (pin_o), .pin_oe (pin_oe), .level (lvl),
    .pin_i (pin_i), .fixed_clk (fsc)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] x = RESP_OKAY);
    int n;
    n = 0;
    @(posedge clk);
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= {24'h000000, d};
    BREADY <= 1'b1;
    do begin
      @(posedge clk);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      n++;
    end while (!BVALID && n < 100);
    BREADY <= 1'b0;
    `CHK("bvalid", 1'b1, BVALID)
    `CHK("bresp", x, BRESP)
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    do begin
      @(posedge clk);
      if (ARREADY) ARVALID <= 1'b0;
      n++;
    end while (!RVALID && n < 100);
    RREADY <= 1'b0;
    `CHK("rvalid", 1'b1, RVALID)
    d = RDATA[7:0];
    rsp = RRESP;
  endtask

  task automatic rx(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] d;
    rd(a, d);
    `CHK($sformatf("reg %0h", a), x, d)
  endtask

  // Low byte first, so the high byte comes from the coherent buffer
  task automatic rc(output logic [15:0] v);
    logic [7:0] hb;
    logic [7:0] lb;
    rd(NL, lb);
    rd(NH, hb);
    v = {hb, lb};
  endtask

  task automatic clr(input logic [7:0] a);
    logic [7:0] d;
    rd(a, d);
    wr(a, d & 8'h7F);
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    lvl <= v;
    cyc(10);
  endtask

  task automatic hi(input int n);
    hic = 0;
    repeat (n) begin
      @(posedge clk);
      hic += pin_o;
    end
  endtask

  function automatic bit near(input int g, input int x);
    return g >= x - 3 && g <= x + 3;
  endfunction

  task automatic end_sim();
    $display("compares %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    cyc(40000);
    bad_count++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, bg, lvl, rst_n} = '0;
    AWADDR = '0;
    ARADDR = '0;
    WDATA = '0;
    WSTRB = 4'hF;
    cyc(8);
    rst_n <= 1'b1;
    foreach (regs[i]) rx(regs[i], 8'h00);
    `CHK("oe_reset", 1'b0, pin_oe)
    rd(8'h40, b);
    `CHK("rresp", RESP_SLVERR, rsp)
    wr(8'h40, 8'h5A, RESP_SLVERR);
    $display("test reset done");
    wr(SC, 8'h08);
    wr(NL, 8'h00);
    rd(NH, b);
    cyc(700);
    rd(NL, b);
    `CHK("cnt_lo_held", 1'b1, b < 8'h40)
    rd(NL, b);
    cyc(700);
    wr(SC, 8'h08);
    rd(NH, b);
    `CHK("cnt_hi_live", 1'b1, b >= 8'h02)
    rd(NL, b);
    wr(NH, 8'h00);
    rd(NH, b);
    `CHK("cnt_hi_clear", 8'h00, b)
    rd(NL, l);
    rd(NH, h);
    bg <= 1'b1;
    cyc(5);
    rd(NL, l);
    cyc(300);
    rd(NL, b);
    `CHK("bg_latch_lo", l, b)
    bg <= 1'b0;
    cyc(700);
    rx(NH, h);
    bg <= 1'b1;
    cyc(5);
    rc(v0);
    cyc(300);
    rc(v1);
    `CHK("bg_frozen", v0, v1)
    bg <= 1'b0;
    $display("test counter done");
    wr(MH, 8'h00);
    wr(ML, 8'h20);
    wr(NL, 8'h00);
    cyc(100);
    rx(SC, 8'h88);
    rc(v0);
    `CHK("cnt_le_mod", 1'b1, v0 <= 16'h0020)
    bg <= 1'b1;
    cyc(5);
    rd(SC, b);
    wr(SC, 8'h88);
    rx(SC, 8'h88);
    wr(SC, 8'h48);
    rx(SC, 8'h48);
    `CHK("ovf_irq_off", 1'b0, ovf_irq)
    wr(MH, 8'h00);
    bg <= 1'b0;
    cyc(200);
    rx(SC, 8'h48);
    wr(ML, 8'h20);
    cyc(100);
    rx(SC, 8'hC8);
    `CHK("ovf_irq_on", 1'b1, ovf_irq)
    bg <= 1'b1;
    cyc(5);
    rd(SC, b);
    wr(SC, 8'h28);
    rx(SC, 8'h28);
    bg <= 1'b0;
    cyc(200);
    rx(SC, 8'hA8);
    rc(v0);
    `CHK("center_le_mod", 1'b1, v0 <= 16'h0020)
    $display("test overflow done");
    wr(SC, 8'h08);
    wr(MH, 8'h00);
    wr(ML, 8'h00);
    for (e = 0; e < 4; e++) begin
      wr(CC, 8'h40 | 8'(e << 2));
      clr(CC);
      pin(1'b1);
      rd(CC, b);
      `CHK("rise_flag", e[0], b[7])
      `CHK("ch_irq", e[0], ch_irq)
      `CHK("cap_oe", 1'b0, pin_oe)
      if (e == 1) begin
        rd(VH, h);
        rd(VL, l);
        rc(v1);
        `CHK("capture", 1'b1, 16'(v1 - {h, l}) < 16'd100)
      end
      clr(CC);
      pin(1'b0);
      rd(CC, b);
      `CHK("fall_flag", e[1], b[7])
      clr(CC);
    end
    $display("test capture done");
    wr(VH, 8'h01);
    wr(VL, 8'h00);
    foreach (ord[i]) begin
      wr(CC, 8'h10 | 8'(ord[i] << 2));
      clr(CC);
      wr(NL, 8'h00);
      p = pin_o;
      cyc(400);
      rd(CC, b);
      `CHK("cmp_flag", 1'b1, b[7])
      `CHK("cmp_oe", ord[i] != 2'h0, pin_oe)
      if (ord[i] != 2'h0) `CHK("cmp_pin", ord[i] == 2'h1 ? ~p : ord[i][0], pin_o)
    end
    $display("test compare done");
    wr(NL, 8'h00);
    wr(MH, 8'h00);
    wr(ML, 8'hFF);
    wr(VL, 8'h40);
    wr(VH, 8'h00);
    for (int k = 0; k < 6; k++) begin
      e = k % 3 + 1;
      wr(CC, 8'h20 | 8'(k / 3 << 4) | 8'(e << 2));
      cyc(300);
      hi(256);
      `CHK("epwm_high", 1'b1, near(hic, e == 2 ? 64 : 192))
      `CHK("epwm_oe", 1'b1, pin_oe)
    end
    wr(SC, 8'h28);
    for (int k = 1; k < 3; k++) begin
      wr(CC, 8'(k << 2));
      cyc(600);
      hi(510);
      `CHK("cpwm_high", 1'b1, near(hic, k == 2 ? 128 : 382))
      `CHK("cpwm_oe", 1'b1, pin_oe)
    end
    $display("test pwm done");
    wr(SC, 8'h10);
    wr(NL, 8'h00);
    cyc(800);
    rc(v0);
    `CHK("fixed_rate", 1'b1, v0 > 16'd90 && v0 < 16'd115)
    wr(SC, 8'h00);
    rc(v0);
    cyc(300);
    rc(v1);
    `CHK("no_clock", v0, v1)
    $display("test clock source done");
    end_sim();
  end
endmodule
`undef CHK
`default_nettype wire
